//--- rtl/bsg_pkg.sv
// constants and types shared by the boot select and code guard block
package bsg_pkg;
  // ==========================================================
  // register byte offsets on the avalon slave
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_GUARD = 8'h04;
  localparam logic [7:0] OFS_VTOR = 8'h08;
  localparam logic [7:0] OFS_DENY = 8'h0c;
  // status field positions
  localparam int ST_LVL = 0;
  localparam int ST_DONE = 2;
  localparam int ST_HANDLER = 3;
  localparam int ST_UART = 4;
  localparam int ST_DEBUG = 5;
  localparam int ST_NO_ENTRY = 6;
  localparam int ST_NO_SAMPLE = 7;
  // ==========================================================
  // guard word location and patterns
  localparam logic [31:0] GUARD_ADDR = 32'h0000_02fc;
  localparam logic [31:0] PAT_PARTIAL = 32'h1234_5678;
  localparam logic [31:0] PAT_MASS = 32'h8765_4321;
  localparam logic [31:0] PAT_FULL = 32'h4321_8765;
  localparam logic [31:0] PAT_NO_ENTRY = 32'h4e69_7370;
  localparam logic [31:0] PAT_NO_SAMPLE = 32'h5a5a_a5a5;
  // vector base: 512-byte aligned, below 1 GB
  localparam logic [31:0] VTOR_MASK = 32'h3fff_fe00;
  localparam logic [31:0] VTOR_RST = 32'h0000_0000;
  localparam logic [15:0] DENY_RST = 16'h0000;
  // ==========================================================
  // programming handler command codes
  localparam logic [3:0] CMD_UNLOCK = 4'h0;
  localparam logic [3:0] CMD_ECHO = 4'h1;
  localparam logic [3:0] CMD_WRITE_RAM = 4'h2;
  localparam logic [3:0] CMD_READ_MEM = 4'h3;
  localparam logic [3:0] CMD_PREPARE = 4'h4;
  localparam logic [3:0] CMD_COPY = 4'h5;
  localparam logic [3:0] CMD_GO = 4'h6;
  localparam logic [3:0] CMD_ERASE = 4'h7;
  localparam logic [3:0] CMD_BLANK = 4'h8;
  localparam logic [3:0] CMD_READ_ID = 4'h9;
  localparam logic [3:0] CMD_COMPARE = 4'ha;
  // ==========================================================
  // types
  typedef enum logic [1:0] {LVL_NONE, LVL_PARTIAL, LVL_MASS, LVL_FULL} bsg_level_t;
  typedef enum logic [1:0] {BS_FETCH, BS_WAIT, BS_DECIDE, BS_RUN} bsg_boot_t;
endpackage

//--- rtl/bsg_cmd_if.sv
// command check link between the top and the command gate
interface bsg_cmd_if;
  logic valid;
  logic app_src;
  logic app_run;
  logic all_sectors;
  logic [3:0] code;
  logic [4:0] sector;
  bsg_pkg::bsg_level_t level;
  logic allow;
  logic deny;
  modport gate (input valid, app_src, app_run, all_sectors, code, sector, level,
    output allow, deny);
  modport src (output valid, app_src, app_run, all_sectors, code, sector, level,
    input allow, deny);
endinterface

//--- rtl/bsg_sync.sv
// two-stage synchroniser for pin levels
module bsg_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  // first stage only feeds the second
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      meta_reg <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

//--- rtl/bsg_cmd_gate.sv
// filters handler commands by guard level
module bsg_cmd_gate (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  bsg_cmd_if.gate cmd
);
  logic ok;
  logic erased_reg;
  logic sec0;

  // decide one command; the port it came in on plays no part
  always_comb begin
    sec0 = cmd.all_sectors || (cmd.sector == 5'h00);
    ok = 1'b1;
    if (cmd.app_src) begin
      ok = 1'b1;
    end else begin
      case (cmd.level)
        bsg_pkg::LVL_PARTIAL: begin
          if (cmd.code == bsg_pkg::CMD_READ_MEM || cmd.code == bsg_pkg::CMD_COMPARE) begin
            ok = 1'b0;
          end else if (cmd.code == bsg_pkg::CMD_ERASE || cmd.code == bsg_pkg::CMD_PREPARE
              || cmd.code == bsg_pkg::CMD_COPY) begin
            ok = !sec0;
          end
        end
        bsg_pkg::LVL_MASS: begin
          if (cmd.code == bsg_pkg::CMD_ERASE) begin
            ok = cmd.all_sectors;
          end else if (cmd.code == bsg_pkg::CMD_PREPARE) begin
            ok = cmd.all_sectors || erased_reg;
          end else if (cmd.code == bsg_pkg::CMD_COPY) begin
            ok = erased_reg;
          end else begin
            ok = (cmd.code == bsg_pkg::CMD_WRITE_RAM);
          end
        end
        bsg_pkg::LVL_FULL: ok = !cmd.app_run;
        default: ok = 1'b1;
      endcase
    end
  end

  // registered verdict, one cycle after valid
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cmd.allow <= 1'b0;
      cmd.deny <= 1'b0;
    end else begin
      cmd.allow <= cmd.valid && ok;
      cmd.deny <= cmd.valid && !ok;
    end
  end

  // remembers a completed whole-flash erase until reset
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      erased_reg <= 1'b0;
    end else if (cmd.valid && ok && !cmd.app_src && cmd.code == bsg_pkg::CMD_ERASE
        && cmd.all_sectors) begin
      erased_reg <= 1'b1;
    end
  end

  AST_APP_FREE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cmd.valid && cmd.app_src |=> cmd.allow && !cmd.deny)
    else $error("application call was blocked");
  AST_SECTOR0: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cmd.valid && !cmd.app_src && cmd.level == bsg_pkg::LVL_PARTIAL
    && cmd.code == bsg_pkg::CMD_ERASE && cmd.sector == 5'h00 |=> cmd.deny)
    else $error("sector 0 erase passed at partial level");
  AST_MASS_ONLY: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cmd.valid && !cmd.app_src && cmd.level == bsg_pkg::LVL_MASS
    && cmd.code == bsg_pkg::CMD_READ_MEM |=> cmd.deny && !cmd.allow)
    else $error("read passed at mass erase level");
  AST_FULL_DENY: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cmd.valid && !cmd.app_src && cmd.app_run && cmd.level == bsg_pkg::LVL_FULL
    |=> cmd.deny && !cmd.allow)
    else $error("handler command passed at full lock");
endmodule

//--- rtl/bsg_boot_guard.sv
// boot selection, code read guard and vector base register
// Function
// - guard level comes from flash pattern
// - application flash calls never blocked
// - partial: no debug, sector 0 kept
// - mass: no debug, erase-all then program
// - full: debug refused, handler refused while user code runs
// - full: boot request pin ignored
// - setting turns off pin handler entry
// - setting stops pin sampling at boot
// - every reset runs boot decision first
// - pin low at reset requests handler
// - select pin high uart, low can
// - can handler gets same command set
// - vector base 512-byte aligned only
// - vector base within lowest 1 GB
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
module bsg_boot_guard (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_flash_rd,
  output logic [31:0] o_flash_addr,
  input wire logic [31:0] i_flash_rdata,
  input wire logic i_flash_rvalid,
  input wire logic i_boot_request_pin,
  input wire logic i_boot_port_select_pin,
  input wire logic i_user_code_valid,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_app,
  input wire logic [3:0] i_cmd_code,
  input wire logic [4:0] i_cmd_sector,
  input wire logic i_cmd_all,
  output logic o_cmd_allow,
  output logic o_cmd_deny,
  output logic o_boot_done,
  output logic o_run_user,
  output logic o_run_handler,
  output logic o_handler_uart,
  output logic o_debug_en,
  output logic [1:0] o_guard_level,
  output logic [31:0] o_vector_base
);
  // ==========================================================
  // pins and command gate
  logic [1:0] pins_sync;
  logic req_sync;
  logic port_sync;
  bsg_cmd_if cmd ();

  // pins idle high so reset shows no request
  bsg_sync #(.W(2), .RST_VAL(2'b11)) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_boot_request_pin, i_boot_port_select_pin}),
    .o_sync(pins_sync)
  );
  assign req_sync = pins_sync[1];
  assign port_sync = pins_sync[0];

  bsg_cmd_gate u_gate (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .cmd(cmd)
  );

  // ==========================================================
  // boot sequence state
  bsg_pkg::bsg_boot_t state_reg;
  bsg_pkg::bsg_level_t level_reg;
  bsg_pkg::bsg_level_t level_next;
  logic [31:0] guard_word_reg;
  logic no_entry_reg;
  logic no_entry_next;
  logic no_sample_reg;
  logic no_sample_next;
  logic pin_heeded;
  logic handler_next;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_reg <= bsg_pkg::BS_FETCH;
      o_flash_rd <= 1'b0;
      o_flash_addr <= bsg_pkg::GUARD_ADDR;
    end else begin
      case (state_reg)
        bsg_pkg::BS_FETCH: begin
          o_flash_rd <= 1'b1;
          state_reg <= bsg_pkg::BS_WAIT;
        end
        bsg_pkg::BS_WAIT: begin
          o_flash_rd <= 1'b0;
          if (i_flash_rvalid) begin
            state_reg <= bsg_pkg::BS_DECIDE;
          end
        end
        bsg_pkg::BS_DECIDE: state_reg <= bsg_pkg::BS_RUN;
        default: state_reg <= bsg_pkg::BS_RUN;
      endcase
    end
  end

  always_comb begin
    level_next = bsg_pkg::LVL_NONE;
    no_entry_next = 1'b0;
    no_sample_next = 1'b0;
    // any other word leaves all open
    if (i_flash_rdata == bsg_pkg::PAT_PARTIAL) begin
      level_next = bsg_pkg::LVL_PARTIAL;
    end else if (i_flash_rdata == bsg_pkg::PAT_MASS) begin
      level_next = bsg_pkg::LVL_MASS;
    end else if (i_flash_rdata == bsg_pkg::PAT_FULL) begin
      level_next = bsg_pkg::LVL_FULL;
    end else if (i_flash_rdata == bsg_pkg::PAT_NO_ENTRY) begin
      no_entry_next = 1'b1;
    end else if (i_flash_rdata == bsg_pkg::PAT_NO_SAMPLE) begin
      no_sample_next = 1'b1;
    end
  end

  // captured once per reset, held till next
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      guard_word_reg <= 32'h0000_0000;
      level_reg <= bsg_pkg::LVL_NONE;
      no_entry_reg <= 1'b0;
      no_sample_reg <= 1'b0;
    end else if (state_reg == bsg_pkg::BS_WAIT && i_flash_rvalid) begin
      guard_word_reg <= i_flash_rdata;
      level_reg <= level_next;
      no_entry_reg <= no_entry_next;
      no_sample_reg <= no_sample_next;
    end
  end

  // either pin-off setting drops it too
  always_comb begin
    pin_heeded = (level_reg != bsg_pkg::LVL_FULL) && !no_entry_reg && !no_sample_reg;
    handler_next = !i_user_code_valid || (pin_heeded && !req_sync);
  end

  // decision taken once, after the guard word is known
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_boot_done <= 1'b0;
      o_run_user <= 1'b0;
      o_run_handler <= 1'b0;
      o_handler_uart <= 1'b0;
      o_debug_en <= 1'b0;
      o_guard_level <= 2'b00;
    end else if (state_reg == bsg_pkg::BS_DECIDE) begin
      o_boot_done <= 1'b1;
      o_run_user <= !handler_next;
      o_run_handler <= handler_next;
      o_handler_uart <= port_sync;
      // any guard level locks the debug port
      o_debug_en <= (level_reg == bsg_pkg::LVL_NONE);
      o_guard_level <= level_reg;
    end
  end

  // ==========================================================
  // command check path
  // same filter for uart and can handler
  assign cmd.valid = i_cmd_valid;
  assign cmd.app_src = i_cmd_app;
  assign cmd.app_run = o_run_user;
  assign cmd.all_sectors = i_cmd_all;
  assign cmd.code = i_cmd_code;
  assign cmd.sector = i_cmd_sector;
  assign cmd.level = level_reg;
  assign o_cmd_allow = cmd.allow;
  assign o_cmd_deny = cmd.deny;

  // ==========================================================
  // avalon slave, one wait cycle per access
  logic [15:0] deny_cnt_reg;
  logic [31:0] rd_mux;
  logic [31:0] vtor_next;
  logic [7:0] status;

  always_comb begin
    status = {no_sample_reg, no_entry_reg, o_debug_en, o_handler_uart,
      o_run_handler, o_boot_done, o_guard_level};
    if (i_avs_address == bsg_pkg::OFS_STATUS) begin
      rd_mux = {24'h000000, status};
    end else if (i_avs_address == bsg_pkg::OFS_GUARD) begin
      rd_mux = guard_word_reg;
    end else if (i_avs_address == bsg_pkg::OFS_VTOR) begin
      rd_mux = o_vector_base;
    end else if (i_avs_address == bsg_pkg::OFS_DENY) begin
      rd_mux = {16'h0000, deny_cnt_reg};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // merge byte lanes; clears the low 9 bits
  always_comb begin
    vtor_next = o_vector_base;
    for (int b = 0; b < 4; b++) begin
      if (i_avs_byteenable[b]) begin
        vtor_next[8*b +: 8] = i_avs_writedata[8*b +: 8];
      end
    end
    // top two bits forced low keeps it under 1 GB
    vtor_next = vtor_next & bsg_pkg::VTOR_MASK;
  end

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else if (!o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b1;
    end else if (i_avs_read || i_avs_write) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= i_avs_read ? rd_mux : 32'h0000_0000;
    end
  end

  // write lands at the edge that sees waitrequest low
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_vector_base <= bsg_pkg::VTOR_RST;
    end else if (!o_avs_waitrequest && i_avs_write
        && i_avs_address == bsg_pkg::OFS_VTOR) begin
      o_vector_base <= vtor_next;
    end
  end

  // refused commands, wraps; software sees lock hits
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      deny_cnt_reg <= bsg_pkg::DENY_RST;
    end else if (cmd.deny) begin
      deny_cnt_reg <= deny_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // checks
  AST_DECODE_FULL: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_reg == bsg_pkg::BS_WAIT && i_flash_rvalid && i_flash_rdata == bsg_pkg::PAT_FULL
    |=> level_reg == bsg_pkg::LVL_FULL ##1 o_guard_level == 2'b11)
    else $error("full lock pattern not decoded");
  AST_LOCK_DEBUG: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_boot_done && level_reg != bsg_pkg::LVL_NONE |-> !o_debug_en)
    else $error("debug open under a guard level");
  AST_OPEN_DEBUG: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_boot_done && level_reg == bsg_pkg::LVL_NONE |-> o_debug_en)
    else $error("debug locked with no guard level");
  AST_FULL_PIN: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_reg == bsg_pkg::BS_DECIDE && level_reg == bsg_pkg::LVL_FULL && i_user_code_valid
    |=> o_run_user && !o_run_handler)
    else $error("pin forced handler at full lock");
  AST_NO_ENTRY: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_reg == bsg_pkg::BS_DECIDE && no_entry_reg && i_user_code_valid |=> o_run_user)
    else $error("pin entry not disabled");
  AST_NO_SAMPLE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_reg == bsg_pkg::BS_DECIDE && no_sample_reg && i_user_code_valid |=> o_run_user)
    else $error("pin sampled though disabled");
  AST_PIN_REQ: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_reg == bsg_pkg::BS_DECIDE && pin_heeded && !req_sync |=> o_run_handler)
    else $error("pin request not honoured");
  AST_PORT_SEL: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_reg == bsg_pkg::BS_DECIDE |=> o_handler_uart == $past(port_sync))
    else $error("wrong handler port");
  AST_BOOT_ONCE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(o_boot_done) |-> (o_run_user ^ o_run_handler) ##1 $stable(o_run_user))
    else $error("boot decision not single and stable");
  AST_FETCH_FIRST: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_flash_rd |-> !o_boot_done ##1 !o_flash_rd)
    else $error("guard read not before decision");
  AST_VTOR_ALIGN: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !o_avs_waitrequest && i_avs_write && i_avs_address == bsg_pkg::OFS_VTOR
    |=> o_vector_base[8:0] == 9'h000)
    else $error("vector base not aligned");
  AST_VTOR_RANGE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !o_avs_waitrequest && i_avs_write && i_avs_address == bsg_pkg::OFS_VTOR
    && i_avs_byteenable == 4'hf |=> o_vector_base == ($past(i_avs_writedata) & 32'h3fff_fe00))
    else $error("vector base write wrong");
  AST_DEBUG_BEFORE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !o_boot_done |-> !o_debug_en)
    else $error("debug open before guard word known");
  AST_GUARD_HELD: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_boot_done |=> $stable(o_guard_level) && $stable(guard_word_reg))
    else $error("guard level changed before reset");
  AST_NO_USER: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_reg == bsg_pkg::BS_DECIDE && !i_user_code_valid |=> o_run_handler && !o_run_user)
    else $error("no valid user code but handler not entered");
endmodule

//--- tb/bsg_flash_model.sv
// flash array model that answers the guard word fetch
module bsg_flash_model (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_rd,
  input wire logic [31:0] i_word,
  output logic o_rvalid,
  output logic [31:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // one-cycle read latency, as fast as the fetch walk allows
  // idle data shows the inverse word so a stale sample cannot pass
  always_ff @(posedge i_core_clk) begin
    o_rvalid <= i_rd & !i_sys_rst;
    o_rdata <= i_rd ? i_word : ~i_word;
  end
endmodule

//--- tb/bsg_boot_guard_tb.sv
// self-checking bench for the boot select and code guard block
module bsg_boot_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_sys_rst, i_avs_read, i_avs_write, i_cmd_valid, i_cmd_app, i_cmd_all;
  logic i_boot_request_pin, i_boot_port_select_pin, i_user_code_valid;
  logic [7:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, o_flash_addr, rdata, word, q, o_vector_base;
  logic [3:0] i_avs_byteenable, i_cmd_code;
  logic [4:0] i_cmd_sector;
  logic [1:0] o_guard_level;
  logic o_avs_waitrequest, o_flash_rd, rvalid, o_cmd_allow, o_cmd_deny, o_boot_done;
  logic o_run_user, o_run_handler, o_handler_uart, o_debug_en;
  int errors, n_tests, cycles;
  // ==========================================================
  // design and flash partner
  bsg_boot_guard u_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_flash_rd(o_flash_rd), .o_flash_addr(o_flash_addr), .i_flash_rdata(rdata),
    .i_flash_rvalid(rvalid), .i_boot_request_pin(i_boot_request_pin),
    .i_boot_port_select_pin(i_boot_port_select_pin), .i_user_code_valid(i_user_code_valid),
    .i_cmd_valid(i_cmd_valid), .i_cmd_app(i_cmd_app), .i_cmd_code(i_cmd_code),
    .i_cmd_sector(i_cmd_sector), .i_cmd_all(i_cmd_all), .o_cmd_allow(o_cmd_allow),
    .o_cmd_deny(o_cmd_deny), .o_boot_done(o_boot_done), .o_run_user(o_run_user),
    .o_run_handler(o_run_handler), .o_handler_uart(o_handler_uart), .o_debug_en(o_debug_en),
    .o_guard_level(o_guard_level), .o_vector_base(o_vector_base));
  bsg_flash_model u_flash (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_rd(o_flash_rd),
    .i_word(word), .o_rvalid(rvalid), .o_rdata(rdata));
  // ==========================================================
  // clock and hang guard
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // avalon access: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] be);
    @(posedge i_core_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    i_avs_read <= !wr;
    i_avs_write <= wr;
    // only the bench timeout ends this wait
    do begin
      @(posedge i_core_clk);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  // reset with pins held, then judge the boot decision
  task automatic boot(input logic [31:0] w, input logic pin, input logic sel, input logic uv);
    int n;
    logic [1:0] lvl;
    logic hnd;
    word = w;
    @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    i_boot_request_pin <= pin;
    i_boot_port_select_pin <= sel;
    i_user_code_valid <= uv;
    repeat (6) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_boot_done !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    lvl = (w == bsg_pkg::PAT_PARTIAL) ? 2'h1 : (w == bsg_pkg::PAT_MASS) ? 2'h2 :
      (w == bsg_pkg::PAT_FULL) ? 2'h3 : 2'h0;
    hnd = !uv | (!pin & lvl != 2'h3 & w != bsg_pkg::PAT_NO_ENTRY & w != bsg_pkg::PAT_NO_SAMPLE);
    check(o_guard_level, lvl);
    check(o_flash_addr, bsg_pkg::GUARD_ADDR);
    check(o_debug_en, lvl == 2'h0);
    check(o_run_handler, hnd);
    check(o_run_user, !hnd);
    if (hnd) check(o_handler_uart, sel);
    bus(1'b0, bsg_pkg::OFS_STATUS, 32'h0, 4'hf);
    check(q[7:0], {w == bsg_pkg::PAT_NO_SAMPLE, w == bsg_pkg::PAT_NO_ENTRY, lvl == 2'h0,
      sel, hnd, 1'b1, lvl});
    bus(1'b0, bsg_pkg::OFS_GUARD, 32'h0, 4'hf);
    check(q, w);
  endtask
  // one handler command, answer seen one cycle after it is taken
  task automatic cmd(input logic app, input logic [3:0] c, input logic [4:0] s,
    input logic all, input logic ok);
    @(posedge i_core_clk);
    i_cmd_valid <= 1'b1;
    i_cmd_app <= app;
    i_cmd_code <= c;
    i_cmd_sector <= s;
    i_cmd_all <= all;
    @(posedge i_core_clk);
    i_cmd_valid <= 1'b0;
    @(posedge i_core_clk);
    check(o_cmd_allow, ok);
    check(o_cmd_deny, !ok);
  endtask
  // ==========================================================
  // scenarios
  task automatic test_boot_table();
    logic [31:0] pats [7];
    pats = '{bsg_pkg::PAT_PARTIAL, bsg_pkg::PAT_MASS, bsg_pkg::PAT_FULL,
      bsg_pkg::PAT_NO_ENTRY, bsg_pkg::PAT_NO_SAMPLE, 32'h0000_0000, 32'hffff_ffff};
    for (int i = 0; i < 7; i++) begin
      boot(pats[i], 1'b0, i[0], 1'b1);
    end
    boot(32'h0000_0000, 1'b1, 1'b1, 1'b1);
    boot(bsg_pkg::PAT_FULL, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic test_vector_base();
    boot(32'h0000_0000, 1'b1, 1'b0, 1'b1);
    bus(1'b1, bsg_pkg::OFS_VTOR, 32'hffff_ffff, 4'hf);
    bus(1'b0, bsg_pkg::OFS_VTOR, 32'h0, 4'hf);
    check(q, bsg_pkg::VTOR_MASK);
    check(o_vector_base, bsg_pkg::VTOR_MASK);
    bus(1'b1, bsg_pkg::OFS_VTOR, 32'h0000_0000, 4'h2);
    bus(1'b0, bsg_pkg::OFS_VTOR, 32'h0, 4'hf);
    check(q, 32'h3fff_0000);
    bus(1'b1, bsg_pkg::OFS_STATUS, 32'hffff_ffff, 4'hf);
    bus(1'b0, bsg_pkg::OFS_STATUS, 32'h0, 4'hf);
    check(q[7:0], 8'h24);
    bus(1'b0, 8'h40, 32'h0, 4'hf);
    check(q, 32'h0000_0000);
  endtask
  task automatic test_commands();
    // full lock with user code running: handler refused, app calls pass
    boot(bsg_pkg::PAT_FULL, 1'b0, 1'b1, 1'b1);
    cmd(1'b0, bsg_pkg::CMD_ECHO, 5'h00, 1'b0, 1'b0);
    cmd(1'b1, bsg_pkg::CMD_ERASE, 5'h00, 1'b1, 1'b1);
    // partial on the can port: sector 0 kept
    boot(bsg_pkg::PAT_PARTIAL, 1'b0, 1'b0, 1'b1);
    cmd(1'b0, bsg_pkg::CMD_READ_MEM, 5'h00, 1'b0, 1'b0);
    cmd(1'b0, bsg_pkg::CMD_ERASE, 5'h00, 1'b0, 1'b0);
    cmd(1'b0, bsg_pkg::CMD_ERASE, 5'h03, 1'b0, 1'b1);
    cmd(1'b0, bsg_pkg::CMD_ECHO, 5'h00, 1'b0, 1'b1);
    bus(1'b0, bsg_pkg::OFS_DENY, 32'h0, 4'hf);
    check(q, 32'h0000_0002);
    // mass erase: copy only after a full erase
    boot(bsg_pkg::PAT_MASS, 1'b0, 1'b1, 1'b1);
    cmd(1'b0, bsg_pkg::CMD_COPY, 5'h02, 1'b0, 1'b0);
    cmd(1'b0, bsg_pkg::CMD_READ_MEM, 5'h00, 1'b0, 1'b0);
    cmd(1'b0, bsg_pkg::CMD_PREPARE, 5'h02, 1'b1, 1'b1);
    cmd(1'b0, bsg_pkg::CMD_ERASE, 5'h02, 1'b0, 1'b0);
    cmd(1'b0, bsg_pkg::CMD_ERASE, 5'h00, 1'b1, 1'b1);
    cmd(1'b0, bsg_pkg::CMD_COPY, 5'h02, 1'b0, 1'b1);
    cmd(1'b0, bsg_pkg::CMD_WRITE_RAM, 5'h00, 1'b0, 1'b1);
    cmd(1'b0, bsg_pkg::CMD_READ_ID, 5'h00, 1'b0, 1'b0);
    // no pattern: nothing restricted
    boot(32'h0000_0000, 1'b0, 1'b1, 1'b1);
    cmd(1'b0, bsg_pkg::CMD_COMPARE, 5'h00, 1'b0, 1'b1);
    cmd(1'b0, bsg_pkg::CMD_ERASE, 5'h00, 1'b1, 1'b1);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    errors = 0;
    n_tests = 0;
    cycles = 0;
    word = 32'h0000_0000;
    i_sys_rst = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 8'h00;
    i_avs_writedata = 32'h0000_0000;
    i_avs_byteenable = 4'hf;
    i_cmd_valid = 1'b0;
    i_cmd_app = 1'b0;
    i_cmd_code = 4'h0;
    i_cmd_sector = 5'h00;
    i_cmd_all = 1'b0;
    i_boot_request_pin = 1'b1;
    i_boot_port_select_pin = 1'b1;
    i_user_code_valid = 1'b1;
    test_boot_table();
    test_vector_base();
    test_commands();
    give_verdict();
  end
endmodule
